// ===== verilog/async_port_pkg.sv
package async_port_pkg;

    // control vector layout, byte positions 1..20
    localparam int CV_BYTES = 20;
    localparam int CV_LINE = 1;
    localparam int CV_DUPLEX = 2;
    localparam int CV_CHAR = 3;
    localparam int CV_TIMEOUT = 5;
    localparam int CV_RECORD = 6;
    localparam int CV_BRK_SEND = 9;
    localparam int CV_BRK_DET = 10;

    // field codes
    localparam logic [7:0] RECORD_ENABLE = 8'h01;
    localparam logic [3:0] BREAK_ENABLE = 4'h1;
    localparam logic [3:0] STOP_ONE_HALF = 4'h2;
    localparam logic [3:0] STOP_TWO = 4'h3;
    localparam logic [3:0] PAR_EVEN = 4'h1;
    localparam logic [3:0] PAR_ODD = 4'h3;
    localparam int DUPLEX_FULL_BIT = 1;
    localparam int NULL_DEL_BIT = 0;
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;
    localparam int EOR_BIT = 7;

    // status bit positions
    localparam int ST_BRK_BIT = 0;
    localparam int ST_DSR_BIT = 2;
    localparam int ST_PAR_BIT = 0;
    localparam int ST_OVR_BIT = 1;
    localparam int ST_FRM_BIT = 2;

    // time units
    localparam int BREAK_UNIT_MS = 10;
    localparam int TIMEOUT_UNIT_MS = 100;
    localparam int TIMEOUT_STEPS = TIMEOUT_UNIT_MS / BREAK_UNIT_MS;

    typedef logic [CV_BYTES:1][7:0] ctrl_vec_t;

    typedef struct packed {
        logic [7:0] tx_count;
        logic [7:0] timeout_left;
        logic [7:0] eor_count;
        logic [7:0] rx_count;
        logic [7:0] error_flags;
        logic [7:0] modem_flags;
        logic [7:0] break_flags;
    } status_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3,
        RX_PARITY = 3'h2, RX_STOP = 3'h6
    } rx_state_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3,
        TX_PARITY = 3'h2, TX_STOP = 3'h6, TX_BREAK = 3'h4
    } tx_state_t;

    // clock cycles per bit; rate table kept in tenths of bit/s
    function automatic logic [23:0] bit_cycles(input logic [3:0] code,
                                               input int clk_hz);
        longint rate10;
        case (code)
            4'h0: rate10 = 500;
            4'h1: rate10 = 750;
            4'h2: rate10 = 1000;
            4'h3: rate10 = 1100;
            4'h4: rate10 = 1345;
            4'h5: rate10 = 1500;
            4'h6: rate10 = 2000;
            4'h7: rate10 = 3000;
            4'h8: rate10 = 6000;
            4'h9: rate10 = 12000;
            4'hb: rate10 = 24000;
            4'hd: rate10 = 48000;
            default: rate10 = 96000;
        endcase
        return 24'((longint'(clk_hz) * 10) / rate10);
    endfunction : bit_cycles

endpackage : async_port_pkg

// ===== verilog/async_port_record_timeout_break.sv
`timescale 1ns/100ps

module char_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] cnt;
    } fifo_state_t;

    fifo_state_t q, d;
    logic push, pop;

    assign in_ready = (q.cnt != CW'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data = q.mem[q.rd];
    assign count = q.cnt;

    always_comb begin
        d = q;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : PW'(q.wr + 1'b1);
        end
        if (pop) begin
            d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : PW'(q.rd + 1'b1);
        end
        d.cnt = CW'(q.cnt + CW'(push) - CW'(pop));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : char_fifo

module async_port_record_timeout_break
    import async_port_pkg::*;
#(
    parameter int CLK_HZ = 100_000_000,
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control vector loading
    input wire logic cv_wr,
    input wire logic [4:0] cv_addr,
    input wire logic [7:0] cv_data,
    input wire logic cv_load,
    // status vector
    input wire logic stat_rd,
    output status_t stat_vec,
    // receive side toward host
    input wire logic rx_enable,
    input wire logic turnaround,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    output logic rd_last,
    // transmit side from host
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic break_req,
    // modem
    input wire logic rxd,
    input wire logic dsr,
    output logic txd
);
    localparam int TICK_CYC = CLK_HZ / 1000 * BREAK_UNIT_MS;
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    typedef struct packed {
        ctrl_vec_t shadow;
        ctrl_vec_t cfg;
        status_t stat;
        logic brk_flag;
        logic par_err;
        logic ovr_err;
        logic frm_err;
        logic [7:0] eor_cnt;
        logic [7:0] countdown;
        logic [23:0] pre;
        logic [3:0] tenth;
        logic rx_en_q;
        rx_state_t rx_st;
        logic [23:0] rx_tmr;
        logic [3:0] rx_bits;
        logic [7:0] rx_sh;
        logic rx_par;
        logic [23:0] brk_pre;
        logic [7:0] brk_units;
        tx_state_t tx_st;
        logic [23:0] tx_tmr;
        logic [3:0] tx_bits;
        logic [7:0] tx_sh;
        logic tx_parity;
        logic tx_space;
        logic [7:0] brk_tx_units;
    } port_state_t;

    port_state_t q, d;

    logic tick, tenth_tick, rx_done, rx_push, f_ready, f_valid, pop;
    logic brk_en, rec_en, par_on, par_bad, keep, brk_go, clr_flags;
    logic [3:0] nbits;
    logic [7:0] ch;
    logic [8:0] f_data;
    logic [CW-1:0] f_count;
    logic [23:0] div, stop_len;

    char_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) rx_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(rx_push),
        .in_ready(f_ready),
        .in_data({rec_en && ch[EOR_BIT],
                  (rec_en && ch[EOR_BIT]) ? {1'b0, ch[6:0]} : ch}),
        .out_valid(f_valid),
        .out_ready(rd_ready && rd_valid),
        .out_data(f_data),
        .count(f_count)
    );

    assign rd_valid = f_valid && (!rec_en || q.eor_cnt != '0);
    assign rd_data = f_data[7:0];
    assign rd_last = f_data[8];
    assign stat_vec = q.stat;
    assign txd = !q.tx_space;
    assign tx_ready = (q.tx_st == TX_IDLE) && !brk_go;

    always_comb begin
        d = q;
        tick = 1'b0;
        tenth_tick = 1'b0;
        rx_done = 1'b0;
        rx_push = 1'b0;
        pop = rd_valid && rd_ready;
        div = bit_cycles(q.cfg[CV_LINE][3:0], CLK_HZ);
        case (q.cfg[CV_LINE][7:4])
            STOP_ONE_HALF: stop_len = 24'(div + (div >> 1) - 1'b1);
            STOP_TWO: stop_len = 24'((div << 1) - 1'b1);
            default: stop_len = 24'(div - 1'b1);
        endcase
        nbits = 4'(MIN_DATA_BITS + q.cfg[CV_CHAR][5:4]);
        par_on = (q.cfg[CV_CHAR][3:0] == PAR_EVEN) ||
                 (q.cfg[CV_CHAR][3:0] == PAR_ODD);
        brk_en = (q.cfg[CV_DUPLEX][3:0] == BREAK_ENABLE);
        rec_en = (q.cfg[CV_RECORD] == RECORD_ENABLE);
        ch = q.rx_sh >> (4'h8 - nbits);
        par_bad = par_on && ((^ch ^ q.rx_par) !=
                             (q.cfg[CV_CHAR][3:0] == PAR_ODD));
        brk_go = break_req && brk_en && q.cfg[CV_BRK_SEND] != '0;

        // shared 10 ms time base and 0.1 s step
        if (q.pre == 24'(TICK_CYC - 1)) begin
            d.pre = '0;
            tick = 1'b1;
        end else begin
            d.pre = 24'(q.pre + 1'b1);
        end
        if (tick) begin
            if (q.tenth == 4'(TIMEOUT_STEPS - 1)) begin
                d.tenth = '0;
                tenth_tick = 1'b1;
            end else begin
                d.tenth = 4'(q.tenth + 1'b1);
            end
        end

        // shadow bytes, committed as one unit
        if (cv_wr && cv_addr >= 5'(CV_LINE) && cv_addr <= 5'(CV_BYTES)) begin
            d.shadow[cv_addr] = cv_data;
        end
        if (cv_load) begin
            d.cfg = q.shadow;
        end

        // duplex gates start
        // receiver; half duplex ignores the line while sending
        d.rx_tmr = (q.rx_tmr != '0) ? 24'(q.rx_tmr - 1'b1) : q.rx_tmr;
        case (q.rx_st)
            RX_IDLE: begin
                if (!rxd && (q.cfg[CV_DUPLEX][4 + DUPLEX_FULL_BIT] ||
                             q.tx_st == TX_IDLE)) begin
                    d.rx_st = RX_START;
                    d.rx_tmr = div >> 1;
                end
            end
            RX_START: begin
                if (q.rx_tmr == '0) begin
                    d.rx_st = rxd ? RX_IDLE : RX_DATA;
                    d.rx_tmr = 24'(div - 1'b1);
                    d.rx_bits = '0;
                end
            end
            RX_DATA: begin
                if (q.rx_tmr == '0) begin
                    d.rx_sh = {rxd, q.rx_sh[7:1]};
                    d.rx_bits = 4'(q.rx_bits + 1'b1);
                    d.rx_tmr = 24'(div - 1'b1);
                    if (q.rx_bits == 4'(nbits - 1'b1)) begin
                        d.rx_st = par_on ? RX_PARITY : RX_STOP;
                    end
                end
            end
            RX_PARITY: begin
                if (q.rx_tmr == '0) begin
                    d.rx_par = rxd;
                    d.rx_tmr = 24'(div - 1'b1);
                    d.rx_st = RX_STOP;
                end
            end
            RX_STOP: begin
                if (q.rx_tmr == '0) begin
                    d.rx_st = RX_IDLE;
                    rx_done = 1'b1;
                end
            end
            default: d.rx_st = RX_IDLE;
        endcase

        keep = !(q.cfg[CV_DUPLEX][4 + NULL_DEL_BIT] && ch == '0);
        rx_push = rx_done && keep && f_ready;

        // flags clear first so a same-cycle event survives
        clr_flags = stat_rd || cv_load;
        if (stat_rd) begin
            d.stat.break_flags = {7'h00, q.brk_flag};
            d.stat.modem_flags = 8'(dsr) << ST_DSR_BIT;
            d.stat.error_flags = 8'(q.par_err) << ST_PAR_BIT |
                                 8'(q.ovr_err) << ST_OVR_BIT |
                                 8'(q.frm_err) << ST_FRM_BIT;
            d.stat.rx_count = 8'(f_count);
            d.stat.eor_count = q.eor_cnt;
            d.stat.timeout_left = q.countdown;
            d.stat.tx_count = {7'h00, q.tx_st != TX_IDLE};
        end
        if (clr_flags) begin
            d.brk_flag = 1'b0;
            d.par_err = 1'b0;
            d.ovr_err = 1'b0;
            d.frm_err = 1'b0;
        end
        if (rx_done) begin
            d.frm_err = q.frm_err && !clr_flags || !rxd;
            d.par_err = q.par_err && !clr_flags || par_bad;
            d.ovr_err = q.ovr_err && !clr_flags || (keep && !f_ready);
        end

        d.eor_cnt = 8'(q.eor_cnt + 8'(rx_push && rec_en && ch[EOR_BIT])
                    - 8'(pop && f_data[8]));

        d.rx_en_q = rx_enable;
        if (cv_load) begin
            d.countdown = q.shadow[CV_TIMEOUT];
        end else if ((rx_enable && !q.rx_en_q) || turnaround || rx_done) begin
            d.countdown = q.cfg[CV_TIMEOUT];
        end else if (tenth_tick && rx_enable && q.cfg[CV_TIMEOUT] != '0 &&
                     q.countdown != '0) begin
            d.countdown = 8'(q.countdown - 1'b1);
        end

        // break timer gated, restarts at mark
        if (!brk_en || rxd) begin
            d.brk_pre = '0;
            d.brk_units = '0;
        end else if (q.brk_pre == 24'(TICK_CYC - 1)) begin
            d.brk_pre = '0;
            d.brk_units = (q.brk_units == 8'hff) ? q.brk_units :
                          8'(q.brk_units + 1'b1);
            if (8'(q.brk_units + 1'b1) == q.cfg[CV_BRK_DET] &&
                q.cfg[CV_BRK_DET] != '0) begin
                d.brk_flag = 1'b1;
            end
        end else begin
            d.brk_pre = 24'(q.brk_pre + 1'b1);
        end

        // transmitter
        d.tx_tmr = (q.tx_tmr != '0) ? 24'(q.tx_tmr - 1'b1) : q.tx_tmr;
        case (q.tx_st)
            TX_IDLE: begin
                d.tx_space = 1'b0;
                if (brk_go) begin
                    d.tx_st = TX_BREAK;
                    d.tx_space = 1'b1;
                    d.brk_tx_units = '0;
                end else if (tx_valid) begin
                    d.tx_st = TX_START;
                    d.tx_space = 1'b1;
                    d.tx_tmr = 24'(div - 1'b1);
                    d.tx_sh = tx_data;
                    d.tx_bits = '0;
                    d.tx_parity = ^(tx_data & 8'(8'hff >> (4'h8 - nbits))) ^
                                  (q.cfg[CV_CHAR][3:0] == PAR_ODD);
                end
            end
            TX_START: begin
                if (q.tx_tmr == '0) begin
                    d.tx_st = TX_DATA;
                    d.tx_space = !q.tx_sh[0];
                    d.tx_tmr = 24'(div - 1'b1);
                end
            end
            TX_DATA: begin
                if (q.tx_tmr == '0) begin
                    d.tx_bits = 4'(q.tx_bits + 1'b1);
                    d.tx_sh = q.tx_sh >> 1;
                    d.tx_tmr = 24'(div - 1'b1);
                    d.tx_space = !q.tx_sh[1];
                    if (q.tx_bits == 4'(nbits - 1'b1)) begin
                        if (par_on) begin
                            d.tx_st = TX_PARITY;
                            d.tx_space = !q.tx_parity;
                        end else begin
                            d.tx_st = TX_STOP;
                            d.tx_space = 1'b0;
                            d.tx_tmr = stop_len;
                        end
                    end
                end
            end
            TX_PARITY: begin
                if (q.tx_tmr == '0) begin
                    d.tx_st = TX_STOP;
                    d.tx_space = 1'b0;
                    d.tx_tmr = stop_len;
                end
            end
            TX_STOP: begin
                if (q.tx_tmr == '0) begin
                    d.tx_st = TX_IDLE;
                end
            end
            TX_BREAK: begin
                // send time in 10 ms units
                if (tick) begin
                    d.brk_tx_units = 8'(q.brk_tx_units + 1'b1);
                    if (8'(q.brk_tx_units + 1'b1) >= q.cfg[CV_BRK_SEND]) begin
                        d.tx_st = TX_IDLE;
                        d.tx_space = 1'b0;
                    end
                end
            end
            default: d.tx_st = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : async_port_record_timeout_break

// ===== tb/port_assertions.sv
`timescale 1ns/100ps
module port_assertions
    import async_port_pkg::*;
#(
    parameter int CLK_HZ = 100_000_000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // vector and status
    input wire logic cv_wr,
    input wire logic [4:0] cv_addr,
    input wire logic [7:0] cv_data,
    input wire logic cv_load,
    input wire logic stat_rd,
    input wire status_t stat_vec,
    // receive
    input wire logic rx_enable,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic rd_last,
    // transmit
    input wire logic tx_valid,
    input wire logic tx_ready,
    // modem
    input wire logic rxd,
    input wire logic dsr,
    input wire logic txd
);
    localparam int TICK = CLK_HZ / 100;
    // slack for a full frame of zero bits at the slowest rate
    localparam int FRAME_MAX = 2400;
    logic [7:0] s2_q, s5_q, s9_q, s10_q, c2_q, c5_q, c9_q, c10_q;
    logic [15:0] txlo_q, rxlo_q;
    logic brk_en_q, due_q, brk_on, hit, clr;
    assign brk_on = c2_q[3:0] == BREAK_ENABLE;
    assign clr = stat_rd || cv_load;
    assign hit = brk_on && c10_q != 8'h00 &&
        int'(rxlo_q) == int'(c10_q) * TICK + 4;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {s2_q, s5_q, s9_q, s10_q, c2_q, c5_q, c9_q, c10_q} <= '0;
            {txlo_q, rxlo_q, brk_en_q, due_q} <= '0;
        end else begin
            if (cv_wr && cv_addr == 5'(CV_DUPLEX)) s2_q <= cv_data;
            if (cv_wr && cv_addr == 5'(CV_TIMEOUT)) s5_q <= cv_data;
            if (cv_wr && cv_addr == 5'(CV_BRK_SEND)) s9_q <= cv_data;
            if (cv_wr && cv_addr == 5'(CV_BRK_DET)) s10_q <= cv_data;
            if (cv_load) {c2_q, c5_q, c9_q, c10_q} <= {s2_q, s5_q, s9_q, s10_q};
            txlo_q <= txd ? 16'h0 : txlo_q + 16'(txlo_q != 16'hffff);
            rxlo_q <= (rxd || !brk_on) ? 16'h0 :
                rxlo_q + 16'(rxlo_q != 16'hffff);
            brk_en_q <= brk_on || (brk_en_q && !clr);
            // a read in the hit cycle may already have taken the flag
            due_q <= !clr && (hit || due_q);
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_eor_bit_clear: assert property (
        rd_valid && rd_last |-> !rd_data[EOR_BIT]) else $error("eor bit set");
    a_stat_holds: assert property (
        !stat_rd |=> $stable(stat_vec)) else $error("status moved");
    a_dsr_snap: assert property (
        stat_rd |=> stat_vec.modem_flags[2:0] == {$past(dsr), 2'b00})
        else $error("modem byte wrong");
    a_tmo_load: assert property (
        cv_load && !rx_enable ##[1:2] stat_rd |=>
        stat_vec.timeout_left == c5_q)
        else $error("countdown not reloaded");
    a_tx_start: assert property (
        tx_valid && tx_ready |=> !txd && !tx_ready) else $error("no start bit");
    a_tx_busy: assert property (
        !txd |-> !tx_ready) else $error("ready while line low");
    a_brk_len: assert property (
        int'(txlo_q) <= int'(c9_q) * TICK + FRAME_MAX)
        else $error("line low too long");
    a_brk_gated: assert property (
        stat_rd && !brk_en_q |=> !stat_vec.break_flags[ST_BRK_BIT])
        else $error("break flag while disabled");
    a_brk_seen: assert property (
        stat_rd && due_q |=> stat_vec.break_flags[ST_BRK_BIT])
        else $error("break not flagged");
    c_eor_taken: cover property (rd_valid && rd_last);
    c_brk_read: cover property (stat_rd && due_q);
    c_tx_take: cover property (tx_valid && tx_ready);
endmodule : port_assertions

// ===== tb/modem_model.sv
`timescale 1ns/100ps
module modem_model (
    // clock
    input wire logic clk,
    // serial lines
    output logic rxd,
    input wire logic txd,
    output logic dsr
);
    // modem starts ready (dsr high); line idles at mark
    initial begin
        rxd = 1'b1;
        dsr = 1'b1;
    end
    task automatic send_char(input logic [7:0] ch, input int nb,
                             input int dv);
        repeat (dv) @(posedge clk) rxd <= 1'b0;
        for (int i = 0; i < nb; i++)
            repeat (dv) @(posedge clk) rxd <= ch[i];
        repeat (2 * dv) @(posedge clk) rxd <= 1'b1;
    endtask : send_char
    task automatic hold_low(input int n);
        repeat (n) @(posedge clk) rxd <= 1'b0;
        @(posedge clk) rxd <= 1'b1;
        repeat (40) @(posedge clk);
    endtask : hold_low
    // samples mid bit, clear of the edges where txd moves
    task automatic recv_frame(input int nb, input int dv,
                              output logic [8:0] bits);
        bits = '0;
        @(negedge txd);
        repeat (dv / 2) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            repeat (dv) @(posedge clk);
            bits[i] = txd;
        end
    endtask : recv_frame
endmodule : modem_model

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    import async_port_pkg::*;
    localparam int CLK_HZ = 10_000;
    localparam int TICK = CLK_HZ / 100;
    // rate code 9 gives eight cycles a bit here
    localparam int DIV = 8;
    typedef struct {
        logic [7:0] ch;
        logic [7:0] exp;
        logic avail;
        logic last;
    } row_t;
    row_t rows [3] = '{'{8'h41, 8'h41, 1'b1, 1'b0},
        '{8'h8d, 8'h0d, 1'b1, 1'b1}, '{8'h42, 8'h42, 1'b0, 1'b0}};
    // no shift characters defined, so every width is legal
    logic [7:0] fmts [4] = '{8'h02, 8'h11, 8'h23, 8'h30};
    logic clk, rst_n, cv_wr, cv_load, stat_rd, rx_enable, turnaround;
    logic rd_ready, tx_valid, break_req, rd_valid, rd_last, tx_ready;
    logic rxd, dsr, txd;
    logic [4:0] cv_addr;
    logic [7:0] cv_data, tx_data, rd_data;
    status_t stat_vec;
    int num_errors = 0;
    int compares = 0;
    async_port_record_timeout_break #(.CLK_HZ(CLK_HZ), .FIFO_DEPTH(4)) DUT (
        .clk(clk), .rst_n(rst_n), .cv_wr(cv_wr), .cv_addr(cv_addr),
        .cv_data(cv_data), .cv_load(cv_load), .stat_rd(stat_rd),
        .stat_vec(stat_vec), .rx_enable(rx_enable), .turnaround(turnaround),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .rd_last(rd_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .break_req(break_req), .rxd(rxd), .dsr(dsr),
        .txd(txd));
    modem_model modem (.clk(clk), .rxd(rxd), .txd(txd), .dsr(dsr));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string nm, input logic [63:0] exp,
                         input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : check
    task automatic close_out;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out
    task automatic load_vec(input logic [7:0] b2, input logic [7:0] b3,
                            input logic [7:0] b5, input logic [7:0] b6);
        ctrl_vec_t v;
        v = '0;
        v[CV_LINE] = 8'h19;
        v[CV_DUPLEX] = b2;
        v[CV_CHAR] = b3;
        v[CV_TIMEOUT] = b5;
        v[CV_RECORD] = b6;
        v[CV_BRK_SEND] = 8'h03;
        v[CV_BRK_DET] = 8'h02;
        for (int a = 1; a <= CV_BYTES; a++) begin
            @(posedge clk);
            cv_wr <= 1'b1;
            cv_addr <= 5'(a);
            cv_data <= v[a];
        end
        @(posedge clk);
        cv_wr <= 1'b0;
        cv_load <= 1'b1;
        @(posedge clk);
        cv_load <= 1'b0;
    endtask : load_vec
    task automatic read_stat;
        @(posedge clk);
        stat_rd <= 1'b1;
        @(posedge clk);
        stat_rd <= 1'b0;
        @(negedge clk);
    endtask : read_stat
    task automatic take(output logic [7:0] d, output logic l);
        @(posedge clk);
        rd_ready <= 1'b1;
        @(negedge clk);
        d = rd_data;
        l = rd_last;
        @(posedge clk);
        rd_ready <= 1'b0;
    endtask : take
    // run needs about 10k cycles
    initial begin
        repeat (40_000) @(posedge clk);
        num_errors++;
        close_out;
    end
    initial begin
        logic [7:0] d;
        logic l;
        logic [8:0] got, want;
        int nb, pb, n;
        {cv_wr, cv_load, stat_rd, rx_enable, turnaround} = '0;
        {rd_ready, tx_valid, break_req, cv_addr, cv_data, tx_data} = '0;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        load_vec(8'h01, 8'h30, 8'h00, RECORD_ENABLE);
        foreach (rows[i]) modem.send_char(rows[i].ch, 8, DIV);
        read_stat;
        check("eor_count", 1, stat_vec.eor_count);
        foreach (rows[i]) begin
            @(negedge clk);
            check("rd_valid", rows[i].avail, rd_valid);
            if (rows[i].avail) begin
                take(d, l);
                check("rd_data", rows[i].exp, d);
                check("rd_last", rows[i].last, l);
            end
        end
        read_stat;
        check("eor_left", 0, stat_vec.eor_count);
        load_vec(8'h01, 8'h30, 8'h00, 8'h00);
        take(d, l);
        check("rec_off", 8'h42, d);
        load_vec(8'h11, 8'h30, 8'h00, 8'h00);
        modem.send_char(8'h00, 8, DIV);
        for (int i = 0; i < 5; i++) modem.send_char(8'h61 + 8'(i), 8, DIV);
        read_stat;
        check("overrun", 1, stat_vec.error_flags[ST_OVR_BIT]);
        for (int i = 0; i < 4; i++) begin
            take(d, l);
            check("drain", 8'h61 + 8'(i), d);
        end
        read_stat;
        check("flags_clr", 0, stat_vec.error_flags);
        @(posedge clk) modem.dsr <= 1'b0;
        read_stat;
        check("dsr_low", 0, stat_vec.modem_flags);
        @(posedge clk) modem.dsr <= 1'b1;
        // start bit arrives while sending: only full duplex keeps it
        load_vec(8'h21, 8'h30, 8'h00, 8'h00);
        fork
            begin
                @(posedge clk) tx_valid <= 1'b1;
                @(posedge clk) tx_valid <= 1'b0;
            end
            begin
                @(posedge clk);
                modem.send_char(8'h5a, 8, DIV);
            end
        join
        take(d, l);
        check("full_duplex", 8'h5a, d);
        foreach (fmts[i]) begin
            load_vec(8'h01, fmts[i], 8'h00, 8'h00);
            nb = 5 + int'(fmts[i][7:4]);
            pb = int'(fmts[i][3:0] == PAR_EVEN || fmts[i][3:0] == PAR_ODD);
            want = 9'(8'ha5 & (8'hff >> (8 - nb)));
            if (pb == 1) want[nb] = (^want) ^ (fmts[i][3:0] == PAR_ODD);
            fork
                begin
                    @(posedge clk);
                    tx_valid <= 1'b1;
                    tx_data <= 8'ha5;
                    @(posedge clk);
                    tx_valid <= 1'b0;
                end
                modem.recv_frame(nb + pb, DIV, got);
            join
            check("tx_frame", want, got);
        end
        for (int e = 0; e < 2; e++) begin
            load_vec(e == 0 ? 8'h01 : 8'h00, 8'h30, 8'h00, 8'h00);
            @(posedge clk) break_req <= 1'b1;
            @(posedge clk) break_req <= 1'b0;
            n = 0;
            repeat (4 * TICK) @(negedge clk) n += int'(!txd);
            // first tick of the shared time base may be short
            l = e == 0 ? n >= 2 * TICK - 1 && n <= 3 * TICK + 1 : n == 0;
            check("break_tx", 1, l);
        end
        load_vec(8'h01, 8'h30, 8'h00, 8'h00);
        modem.hold_low(150);
        modem.hold_low(150);
        read_stat;
        check("brk_short", 0, stat_vec.break_flags);
        modem.hold_low(250);
        read_stat;
        check("brk_seen", 1, stat_vec.break_flags);
        read_stat;
        check("brk_clr", 0, stat_vec.break_flags);
        load_vec(8'h00, 8'h30, 8'h00, 8'h00);
        read_stat;
        modem.hold_low(250);
        read_stat;
        check("brk_off", 0, stat_vec.break_flags);
        for (int i = 0; i < 4; i++) take(d, l);
        load_vec(8'h00, 8'h30, 8'h02, 8'h00);
        read_stat;
        check("tmo_load", 2, stat_vec.timeout_left);
        @(posedge clk) rx_enable <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            repeat (31 * TICK) @(posedge clk);
            read_stat;
            check("tmo_zero", 0, stat_vec.timeout_left);
            if (e == 0) modem.send_char(8'h31, 8, DIV);
            else begin
                @(posedge clk) turnaround <= 1'b1;
                @(posedge clk) turnaround <= 1'b0;
            end
            read_stat;
            check("tmo_reload", 1, stat_vec.timeout_left != 0);
        end
        close_out;
    end
endmodule : testbench
bind async_port_record_timeout_break port_assertions #(.CLK_HZ(CLK_HZ)) chk (
    .clk(clk), .rst_n(rst_n), .cv_wr(cv_wr), .cv_addr(cv_addr),
    .cv_data(cv_data), .cv_load(cv_load), .stat_rd(stat_rd),
    .stat_vec(stat_vec), .rx_enable(rx_enable), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_last(rd_last), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rxd(rxd), .dsr(dsr), .txd(txd));
